// file: rtl/bpc_cfg.svh
`ifndef BPC_CFG_SVH
`define BPC_CFG_SVH
// clock and timing
`define BPC_CLK_HZ 25000000
`define BPC_MS_PER_S 1000
`define BPC_MS_CYCLES (`BPC_CLK_HZ / `BPC_MS_PER_S)
`define BPC_CTL_MIN_MS 8'h02
`define BPC_FILT_MAX_MS 8'hFA
// count and setpoint limits
`define BPC_CNT_W 20
`define BPC_SETPOINT_MAX 20'hF423E
`define BPC_CNT_MAX 20'hF423F
`define BPC_COEF_ONE 20'h02710
`define BPC_PULSE_MAX 14'h270F
// serial port
`define BPC_ADDR_MIN 8'h01
`define BPC_ADDR_MAX 8'hF7
`define BPC_BAUD_1200 (`BPC_CLK_HZ / 1200)
`define BPC_BAUD_2400 (`BPC_CLK_HZ / 2400)
`define BPC_BAUD_4800 (`BPC_CLK_HZ / 4800)
`define BPC_BAUD_9600 (`BPC_CLK_HZ / 9600)
`define BPC_BAUD_19200 (`BPC_CLK_HZ / 19200)
`endif

// file: rtl/bpc_pkg.sv
package bpc_pkg;
  typedef logic [19:0] bpc_cnt_t;
  typedef logic [2:0] bpc_code_t;
  // input mode codes
  typedef enum logic [2:0] {
    BPC_INC = 3'h0, BPC_DEC = 3'h1, BPC_INC_DEC = 3'h2,
    BPC_INC_INC = 3'h3, BPC_UP_DOWN = 3'h4, BPC_QX1 = 3'h5,
    BPC_QX2 = 3'h6, BPC_QX4 = 3'h7
  } bpc_mode_e;
  // second output state
  typedef enum logic [2:0] {
    BPC_O2_IDLE = 3'b001, BPC_O2_TIMED = 3'b010, BPC_O2_HOLD = 3'b100
  } bpc_o2_e;
endpackage

// file: rtl/bpc_pulse_if.sv
`timescale 1ns/1ps
// filtered pulse line with its edges
interface bpc_pulse_if;
  logic level;
  logic rise;
  logic fall;
  modport src (output level, rise, fall);
  modport snk (input level, rise, fall);
endinterface

// file: rtl/bpc_filter.sv
`timescale 1ns/1ps
module bpc_filter (
  // clock
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic clk_en_in,
  input wire logic ms_tick_in,
  // setting and pin
  input wire logic [7:0] limit_ms_in,
  input wire logic raw_in,
  // filtered result
  bpc_pulse_if.src pulse
);
  logic sync1_r;
  logic sync2_r;
  logic filt_r;
  logic rise_r;
  logic fall_r;
  logic [7:0] held_r;
  logic differs;
  logic accept;
  logic [7:0] held_nxt;

  // accept once the new level has stood for the limit
  assign differs = sync2_r != filt_r;
  assign accept = differs &&
    (limit_ms_in == 8'h00 || (ms_tick_in && held_r + 8'h01 >= limit_ms_in));
  assign held_nxt = !differs ? 8'h00 :
    (ms_tick_in ? held_r + 8'h01 : held_r);

  // two-flop synchroniser
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
    end else if (clk_en_in) begin
      sync1_r <= raw_in;
      sync2_r <= sync1_r;
    end
  end

  // width filter and single-cycle edge pulses
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      filt_r <= 1'b0;
      held_r <= 8'h00;
      rise_r <= 1'b0;
      fall_r <= 1'b0;
    end else if (clk_en_in) begin
      held_r <= accept ? 8'h00 : held_nxt;
      filt_r <= accept ? sync2_r : filt_r;
      rise_r <= accept && sync2_r;
      fall_r <= accept && !sync2_r;
    end
  end

  assign pulse.level = filt_r;
  assign pulse.rise = rise_r;
  assign pulse.fall = fall_r;
endmodule

// file: rtl/bpc_top.sv
`timescale 1ns/1ps
`include "bpc_cfg.svh"
module bpc_top #(
  parameter int unsigned MS_CYCLES = `BPC_MS_CYCLES
) (
  // clock, reset, enable
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic clk_en_in,
  // pulse pins and front panel key
  input wire logic first_pulse_channel_in,
  input wire logic second_pulse_channel_in,
  input wire logic reset_pin_in,
  input wire logic pause_pin_in,
  input wire logic reset_key_in,
  // counting configuration
  input wire bpc_pkg::bpc_code_t input_mode_in,
  input wire logic [7:0] filter_ms_in,
  input wire logic batch_auto_in,
  input wire logic decrement_mode_in,
  input wire bpc_pkg::bpc_cnt_t batch_setpoint_in,
  input wire bpc_pkg::bpc_cnt_t count_setpoint_in,
  input wire logic batch_shown_in,
  input wire bpc_pkg::bpc_cnt_t coef_in,
  input wire bpc_pkg::bpc_code_t dp_sel_in,
  input wire bpc_pkg::bpc_code_t lockout_in,
  // output configuration
  input wire logic out1_idle_on_in,
  input wire logic out2_idle_on_in,
  input wire logic [13:0] out2_pulse_ms_in,
  // retention
  input wire logic retain_en_in,
  input wire logic power_fail_in,
  input wire logic nv_restore_in,
  input wire bpc_pkg::bpc_cnt_t nv_data_in,
  // serial configuration and address check
  input wire logic [7:0] slave_addr_in,
  input wire logic rtu_sel_in,
  input wire logic parity_odd_in,
  input wire bpc_pkg::bpc_code_t baud_sel_in,
  input wire logic stop_two_in,
  input wire logic [7:0] rx_addr_in,
  input wire logic rx_addr_valid_in,
  // relay outputs
  output logic out1_out,
  output logic out2_out,
  // counts and display
  output bpc_pkg::bpc_cnt_t count_out,
  output bpc_pkg::bpc_cnt_t batch_count_out,
  output bpc_pkg::bpc_cnt_t scaled_count_out,
  output logic [4:0] dp_mask_out,
  // panel enables
  output logic reset_key_en_out,
  output logic batch_sp_edit_en_out,
  output logic count_sp_edit_en_out,
  // retention
  output logic nv_store_out,
  output bpc_pkg::bpc_cnt_t nv_data_out,
  // serial settings
  output logic [15:0] baud_div_out,
  output logic rtu_mode_out,
  output logic parity_odd_out,
  output logic stop_two_out,
  output logic addr_hit_out
);
  import bpc_pkg::*;

  // ----------------------------------------------------------------
  // millisecond tick
  // ----------------------------------------------------------------
  logic [15:0] ms_cnt_r;
  logic ms_tick;
  assign ms_tick = ms_cnt_r == 16'(MS_CYCLES - 1);
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      ms_cnt_r <= 16'h0000;
    end else if (clk_en_in) begin
      ms_cnt_r <= ms_tick ? 16'h0000 : ms_cnt_r + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // input filters
  // ----------------------------------------------------------------
  logic [7:0] chan_lim, ctl_lim;
  // clamp to 250 ms; zero bypasses the channels
  assign chan_lim = filter_ms_in > `BPC_FILT_MAX_MS ?
    `BPC_FILT_MAX_MS : filter_ms_in;
  assign ctl_lim = filter_ms_in <= 8'h01 ? `BPC_CTL_MIN_MS : chan_lim;
  bpc_pulse_if ch1_if ();
  bpc_pulse_if ch2_if ();
  bpc_pulse_if rst_if ();
  bpc_pulse_if pau_if ();
  bpc_filter u_ch1 (.sys_clk_in(sys_clk_in), .reset_in(reset_in),
    .clk_en_in(clk_en_in), .ms_tick_in(ms_tick), .limit_ms_in(chan_lim),
    .raw_in(first_pulse_channel_in), .pulse(ch1_if.src));
  bpc_filter u_ch2 (.sys_clk_in(sys_clk_in), .reset_in(reset_in),
    .clk_en_in(clk_en_in), .ms_tick_in(ms_tick), .limit_ms_in(chan_lim),
    .raw_in(second_pulse_channel_in), .pulse(ch2_if.src));
  bpc_filter u_rst (.sys_clk_in(sys_clk_in), .reset_in(reset_in),
    .clk_en_in(clk_en_in), .ms_tick_in(ms_tick), .limit_ms_in(ctl_lim),
    .raw_in(reset_pin_in), .pulse(rst_if.src));
  bpc_filter u_pau (.sys_clk_in(sys_clk_in), .reset_in(reset_in),
    .clk_en_in(clk_en_in), .ms_tick_in(ms_tick), .limit_ms_in(ctl_lim),
    .raw_in(pause_pin_in), .pulse(pau_if.src));

  // ----------------------------------------------------------------
  // count event decode
  // ----------------------------------------------------------------
  logic a_lv, b_lv, a_r, a_f, b_r, b_f;
  logic qa_up, qa_dn, qb_up, qb_dn;
  logic [1:0] inc_n, dec_n;
  bpc_mode_e mode;
  assign mode = bpc_mode_e'(input_mode_in);
  assign a_lv = ch1_if.level;
  assign b_lv = ch2_if.level;
  assign a_r = ch1_if.rise;
  assign a_f = ch1_if.fall;
  assign b_r = ch2_if.rise;
  assign b_f = ch2_if.fall;
  // quadrature direction from the other channel's level
  assign qa_up = (a_r && !b_lv) || (a_f && b_lv);
  assign qa_dn = (a_r && b_lv) || (a_f && !b_lv);
  assign qb_up = (b_r && a_lv) || (b_f && !a_lv);
  assign qb_dn = (b_r && !a_lv) || (b_f && a_lv);

  // up and down events per cycle
  always_comb begin
    inc_n = 2'h0;
    dec_n = 2'h0;
    unique case (mode)
      BPC_INC: inc_n = {1'b0, a_r};
      BPC_DEC: dec_n = {1'b0, a_r};
      BPC_INC_DEC: begin
        inc_n = {1'b0, a_r};
        dec_n = {1'b0, b_r};
      end
      BPC_INC_INC: inc_n = {1'b0, a_r} + {1'b0, b_r};
      BPC_UP_DOWN: begin
        inc_n = {1'b0, a_r && !b_lv};
        dec_n = {1'b0, a_r && b_lv};
      end
      BPC_QX1: begin
        inc_n = {1'b0, a_r && !b_lv};
        dec_n = {1'b0, a_f && !b_lv};
      end
      BPC_QX2: begin
        inc_n = {1'b0, qa_up};
        dec_n = {1'b0, qa_dn};
      end
      BPC_QX4: begin
        inc_n = {1'b0, qa_up} + {1'b0, qb_up};
        dec_n = {1'b0, qa_dn} + {1'b0, qb_dn};
      end
    endcase
  end

  // ----------------------------------------------------------------
  // normal count
  // ----------------------------------------------------------------
  bpc_cnt_t cnt_r, batch_r;
  bpc_cnt_t sp1, sp2, preset, cnt_nxt, batch_inc;
  logic signed [21:0] step, sum;
  logic counting, reach, key_d_r, key_ev, man_rst;
  logic clr_batch, clr_count, batch_hit;

  // setpoints capped
  assign sp1 = batch_setpoint_in > `BPC_SETPOINT_MAX ?
    `BPC_SETPOINT_MAX : batch_setpoint_in;
  assign sp2 = count_setpoint_in > `BPC_SETPOINT_MAX ?
    `BPC_SETPOINT_MAX : count_setpoint_in;
  assign preset = decrement_mode_in ? sp2 : 20'h00000;

  // increment pulses move toward the target in either count direction; decrement pulses move away from it
  assign step = 22'(signed'({1'b0, inc_n})) - 22'(signed'({1'b0, dec_n}));
  assign sum = decrement_mode_in ? 22'(signed'({2'b00, cnt_r})) - step :
    22'(signed'({2'b00, cnt_r})) + step;
  assign counting = !pau_if.level && step != 22'sh0;
  assign reach = counting && (decrement_mode_in ? sum <= 22'sh0 :
    sum >= 22'(signed'({2'b00, sp2})));
  assign cnt_nxt = sum < 22'sh0 ? 20'h00000 :
    (sum > 22'(signed'({2'b00, `BPC_CNT_MAX})) ? `BPC_CNT_MAX : sum[19:0]);

  // manual reset from pin or unlocked key
  assign key_ev = reset_key_in && !key_d_r && reset_key_en_out;
  assign man_rst = rst_if.rise || key_ev;
  assign clr_batch = man_rst && batch_shown_in;
  assign clr_count = man_rst && !batch_shown_in;

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      cnt_r <= 20'h00000;
      key_d_r <= 1'b0;
    end else if (clk_en_in) begin
      key_d_r <= reset_key_in;
      if (nv_restore_in && retain_en_in) begin
        cnt_r <= nv_data_in > `BPC_CNT_MAX ? `BPC_CNT_MAX : nv_data_in;
      end else if (clr_count || reach) begin
        cnt_r <= preset;
      end else if (counting) begin
        cnt_r <= cnt_nxt;
      end
    end
  end

  // ----------------------------------------------------------------
  // batch count and first output
  // ----------------------------------------------------------------
  logic out1_act_r;
  assign batch_inc = batch_r == `BPC_CNT_MAX ? batch_r : batch_r + 20'h1;
  assign batch_hit = reach && batch_inc == sp1;

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      batch_r <= 20'h00000;
      out1_act_r <= 1'b0;
    end else if (clk_en_in) begin
      if (clr_batch) begin
        batch_r <= 20'h00000;
        out1_act_r <= 1'b0;
      end else if (batch_hit && batch_auto_in) begin
        batch_r <= 20'h00000;
        out1_act_r <= 1'b1;
      end else if (reach) begin
        batch_r <= batch_inc;
        out1_act_r <= batch_auto_in ? 1'b0 : batch_inc >= sp1;
      end
    end
  end

  // ----------------------------------------------------------------
  // second output timing
  // ----------------------------------------------------------------
  bpc_o2_e o2_r, o2_nxt;
  logic [13:0] o2_tmr_r, o2_tmr_nxt, pulse_ms;
  assign pulse_ms = out2_pulse_ms_in > `BPC_PULSE_MAX ?
    `BPC_PULSE_MAX : out2_pulse_ms_in;
  always_comb begin
    o2_nxt = o2_r;
    o2_tmr_nxt = o2_tmr_r;
    if (reach) begin
      o2_nxt = pulse_ms == 14'h0000 ? BPC_O2_HOLD : BPC_O2_TIMED;
      o2_tmr_nxt = pulse_ms;
    end else begin
      unique case (o2_r)
        BPC_O2_IDLE: o2_nxt = BPC_O2_IDLE;
        BPC_O2_TIMED: begin
          if (ms_tick) begin
            o2_tmr_nxt = o2_tmr_r - 14'h0001;
            o2_nxt = o2_tmr_r <= 14'h0001 ? BPC_O2_IDLE : BPC_O2_TIMED;
          end
        end
        BPC_O2_HOLD: o2_nxt = clr_count ? BPC_O2_IDLE : BPC_O2_HOLD;
        default: o2_nxt = BPC_O2_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      o2_r <= BPC_O2_IDLE;
      o2_tmr_r <= 14'h0000;
    end else if (clk_en_in) begin
      o2_r <= o2_nxt;
      o2_tmr_r <= o2_tmr_nxt;
    end
  end

  // ----------------------------------------------------------------
  // scaling, decimal point, panel lockout
  // ----------------------------------------------------------------
  logic [39:0] prod, quot;
  logic [4:0] dp_mask;
  logic key_en, sp1_en, sp2_en;
  // coefficient carries four decimals; 1.0000 is unity
  assign prod = 40'(cnt_r) * 40'(coef_in);
  assign quot = prod / 40'(`BPC_COEF_ONE);
  assign dp_mask = dp_sel_in > 3'h4 ? 5'h00 :
    5'(5'h01 << dp_sel_in) & 5'h1E;
  assign key_en = lockout_in != 3'h1 && lockout_in != 3'h3;
  assign sp1_en = lockout_in == 3'h0 || lockout_in == 3'h1 ||
    lockout_in == 3'h5;
  assign sp2_en = lockout_in == 3'h0 || lockout_in == 3'h1 ||
    lockout_in == 3'h4;

  // ----------------------------------------------------------------
  // serial settings and address match
  // ----------------------------------------------------------------
  logic [15:0] baud_div;
  logic addr_ok;
  assign baud_div =
    baud_sel_in == 3'h0 ? 16'(`BPC_BAUD_1200) :
    baud_sel_in == 3'h1 ? 16'(`BPC_BAUD_2400) :
    baud_sel_in == 3'h2 ? 16'(`BPC_BAUD_4800) :
    baud_sel_in == 3'h4 ? 16'(`BPC_BAUD_19200) :
    16'(`BPC_BAUD_9600);
  assign addr_ok = slave_addr_in >= `BPC_ADDR_MIN &&
    slave_addr_in <= `BPC_ADDR_MAX && rx_addr_in == slave_addr_in;

  // ----------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      out1_out <= 1'b0;
      out2_out <= 1'b0;
      count_out <= 20'h00000;
      batch_count_out <= 20'h00000;
      scaled_count_out <= 20'h00000;
      dp_mask_out <= 5'h00;
      reset_key_en_out <= 1'b0;
      batch_sp_edit_en_out <= 1'b0;
      count_sp_edit_en_out <= 1'b0;
      nv_store_out <= 1'b0;
      nv_data_out <= 20'h00000;
      baud_div_out <= 16'(`BPC_BAUD_9600);
      rtu_mode_out <= 1'b0;
      parity_odd_out <= 1'b0;
      stop_two_out <= 1'b0;
      addr_hit_out <= 1'b0;
    end else if (clk_en_in) begin
      out1_out <= out1_act_r ^ out1_idle_on_in;
      out2_out <= (o2_r != BPC_O2_IDLE) ^ out2_idle_on_in;
      count_out <= cnt_r;
      batch_count_out <= batch_r;
      scaled_count_out <= quot > 40'(`BPC_CNT_MAX) ?
        `BPC_CNT_MAX : quot[19:0];
      dp_mask_out <= dp_mask;
      reset_key_en_out <= key_en;
      batch_sp_edit_en_out <= sp1_en;
      count_sp_edit_en_out <= sp2_en;
      nv_store_out <= power_fail_in && retain_en_in;
      nv_data_out <= cnt_r;
      baud_div_out <= baud_div;
      rtu_mode_out <= rtu_sel_in;
      parity_odd_out <= parity_odd_in;
      stop_two_out <= stop_two_in;
      addr_hit_out <= rx_addr_valid_in && addr_ok;
    end
  end
endmodule

// file: testbench/bpc_top_checker.sv
`timescale 1ns/1ps
module bpc_top_checker (
  // clock, reset and enable
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic clk_en_in,
  // settings and requests
  input wire bpc_pkg::bpc_code_t dp_sel_in,
  input wire bpc_pkg::bpc_code_t lockout_in,
  input wire bpc_pkg::bpc_code_t baud_sel_in,
  input wire bpc_pkg::bpc_cnt_t coef_in,
  input wire logic retain_en_in,
  input wire logic power_fail_in,
  input wire logic rtu_sel_in,
  input wire logic parity_odd_in,
  input wire logic stop_two_in,
  input wire logic [7:0] slave_addr_in,
  input wire logic [7:0] rx_addr_in,
  input wire logic rx_addr_valid_in,
  // results
  input wire bpc_pkg::bpc_cnt_t count_out,
  input wire bpc_pkg::bpc_cnt_t scaled_count_out,
  input wire logic [4:0] dp_mask_out,
  input wire logic reset_key_en_out,
  input wire logic batch_sp_edit_en_out,
  input wire logic count_sp_edit_en_out,
  input wire logic nv_store_out,
  input wire logic [15:0] baud_div_out,
  input wire logic rtu_mode_out,
  input wire logic parity_odd_out,
  input wire logic stop_two_out,
  input wire logic addr_hit_out
);
  import bpc_pkg::*;
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (reset_in);
  // qualifiers for the request side
  wire logic run = clk_en_in && !reset_in;
  wire logic hit = rx_addr_valid_in && rx_addr_in == slave_addr_in;
  wire logic addr_ok = slave_addr_in >= 8'h01 && slave_addr_in <= 8'hF7;
  // expected divider per rate code
  function automatic logic [15:0] div_f(input logic [2:0] s);
    case (s)
      3'h0: return 16'h5161;
      3'h1: return 16'h28B0;
      3'h2: return 16'h1458;
      3'h4: return 16'h0516;
      default: return 16'h0A2C;
    endcase
  endfunction
  // expected point mask and panel enables
  function automatic logic [4:0] dp_f(input logic [2:0] s);
    return (s >= 3'h1 && s <= 3'h4) ? 5'h01 << s : 5'h00;
  endfunction
  function automatic logic [2:0] lock_f(input logic [2:0] l);
    return {!(l == 3'h1 || l == 3'h3), !(l == 3'h2 || l == 3'h3 ||
      l == 3'h4), !(l == 3'h2 || l == 3'h3 || l == 3'h5)};
  endfunction
  // ----------------------------------------
  // properties
  // ----------------------------------------
  sequence s_unity;
    (coef_in == 20'h02710 && $stable(count_out)) [*3];
  endsequence
  AST_BAUD_DIV: assert property (run |=>
    baud_div_out == div_f($past(baud_sel_in))) else $error("baud divider");
  AST_SER_COPY: assert property (run |=> rtu_mode_out == $past(rtu_sel_in)
    && parity_odd_out == $past(parity_odd_in)
    && stop_two_out == $past(stop_two_in)) else $error("serial copy");
  AST_STOP_BITS: assert property ($rose(stop_two_in) && run |=>
    stop_two_out) else $error("stop bits");
  AST_ADDR_HIT: assert property (run && hit && addr_ok |=> addr_hit_out)
    else $error("address hit missing");
  AST_ADDR_MISS: assert property (run && !(hit && addr_ok) |=>
    !addr_hit_out) else $error("address hit unexpected");
  AST_DP_MASK: assert property (run |=>
    dp_mask_out == dp_f($past(dp_sel_in))) else $error("point mask");
  AST_LOCKOUT: assert property (run |=> $past(lockout_in) > 3'h5 ||
    {reset_key_en_out, batch_sp_edit_en_out, count_sp_edit_en_out} ==
    lock_f($past(lockout_in))) else $error("panel lockout");
  AST_NV_STORE: assert property (run && retain_en_in && power_fail_in
    |=> nv_store_out) else $error("store missing");
  AST_NV_NONE: assert property (run && !retain_en_in |=> !nv_store_out)
    else $error("store without retention");
  AST_UNITY: assert property (s_unity |->
    scaled_count_out == count_out) else $error("unity scaling");
endmodule
bind bpc_top bpc_top_checker CHK (.*);

// file: testbench/bpc_pulse_src.sv
`timescale 1ns/1ps
module bpc_pulse_src (
  // clock
  input wire logic sys_clk_in,
  // sensor or encoder pins
  output logic first_pulse_channel_out,
  output logic second_pulse_channel_out
);
  // both pins idle low
  initial begin
    first_pulse_channel_out = 1'b0;
    second_pulse_channel_out = 1'b0;
  end
  // pins move together just after an edge
  task automatic set_pins(input logic a, input logic b);
    @(posedge sys_clk_in);
    #1;
    first_pulse_channel_out = a;
    second_pulse_channel_out = b;
  endtask
endmodule

// file: testbench/batch_pulse_counter_tb.sv
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin num_errors++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module batch_pulse_counter_tb;
  import bpc_pkg::*;
  // ----------------------------------------
  // design inputs and outputs
  // ----------------------------------------
  logic sys_clk_in = 1'b0, reset_in = 1'b1, clk_en_in = 1'b1;
  logic first_pulse_channel_in, second_pulse_channel_in;
  logic reset_pin_in = 1'b0, pause_pin_in = 1'b0, reset_key_in = 1'b0;
  bpc_code_t input_mode_in = 3'h0, dp_sel_in = 3'h0, lockout_in = 3'h0;
  bpc_code_t baud_sel_in = 3'h0;
  logic [7:0] filter_ms_in = 8'h00, slave_addr_in = 8'h01;
  logic [7:0] rx_addr_in = 8'h00;
  logic batch_auto_in = 1'b0, decrement_mode_in = 1'b0;
  logic batch_shown_in = 1'b0;
  bpc_cnt_t batch_setpoint_in = 20'h00002, count_setpoint_in = 20'h003E8;
  bpc_cnt_t coef_in = 20'h02710, nv_data_in = 20'h00000;
  logic out1_idle_on_in = 1'b0, out2_idle_on_in = 1'b1;
  logic [13:0] out2_pulse_ms_in = 14'h0000;
  logic retain_en_in = 1'b0, power_fail_in = 1'b0, nv_restore_in = 1'b0;
  logic rtu_sel_in = 1'b0, parity_odd_in = 1'b0, stop_two_in = 1'b0;
  logic rx_addr_valid_in = 1'b0;
  logic out1_out, out2_out, nv_store_out, rtu_mode_out, parity_odd_out;
  logic stop_two_out, addr_hit_out;
  logic reset_key_en_out, batch_sp_edit_en_out, count_sp_edit_en_out;
  bpc_cnt_t count_out, batch_count_out, scaled_count_out, nv_data_out;
  logic [4:0] dp_mask_out;
  logic [15:0] baud_div_out;
  // bench state
  int num_errors = 0, check_count = 0;
  bpc_cnt_t exp_q[$], exp_cnt = 20'h00000, last_cnt;
  logic mon_on = 1'b0;
  logic [31:0] seed = 32'hB745C02B;
  // mode, pin a, pin b, signed count step
  localparam logic [7:0] STEPS [34] = '{8'h11, 8'h00, 8'h11, 8'h00,
    8'h37, 8'h20, 8'h51, 8'h5F, 8'h40, 8'h71, 8'h79, 8'h60, 8'h88, 8'h9F,
    8'h88, 8'h80, 8'h91, 8'h80, 8'hB1, 8'hB8, 8'hA8, 8'hA0, 8'hD1, 8'hD8,
    8'hC9, 8'hC0, 8'hF1, 8'hF9, 8'hE9, 8'hE1, 8'hEF, 8'hFF, 8'hF7, 8'hE7};
  // 25 MHz clock
  always #20 sys_clk_in = ~sys_clk_in;
  bpc_pulse_src SRC (.sys_clk_in(sys_clk_in),
    .first_pulse_channel_out(first_pulse_channel_in),
    .second_pulse_channel_out(second_pulse_channel_in));
  bpc_top #(.MS_CYCLES(4)) DUT (.*);
  // each count change against the oldest note
  always @(posedge sys_clk_in) begin
    if (mon_on && count_out !== last_cnt) begin
      if (exp_q.size() == 0) begin
        `CHK(count_out, last_cnt)
      end else begin
        `CHK(count_out, exp_q.pop_front())
      end
    end
    last_cnt <= count_out;
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask
  task automatic summarize();
    $display("errors=%0d checks=%0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // move pins and note the count they give
  task automatic ev(input logic a, input logic b, input int d);
    SRC.set_pins(a, b);
    exp_cnt = exp_cnt + bpc_cnt_t'(d);
    if (d != 0) exp_q.push_back(exp_cnt);
    step(10);
  endtask
  task automatic pul(input int n);
    repeat (n) begin
      ev(1'b1, 1'b0, 0);
      ev(1'b0, 1'b0, 0);
    end
  endtask
  task automatic key();
    reset_key_in = 1'b1;
    step(20);
    reset_key_in = 1'b0;
    step(12);
  endtask
  task automatic wait_bc(input bpc_cnt_t v);
    int i;
    for (i = 0; i < 200 && batch_count_out !== v; i++) step(1);
    if (i == 200) begin
      num_errors++;
      summarize();
    end else step(2);
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    step(20);
    reset_in = 1'b0;
    step(3);
    `CHK({out1_out, out2_out}, 2'b01)
    mon_on = 1'b1;
    foreach (STEPS[i]) begin
      input_mode_in = STEPS[i][7:5];
      ev(STEPS[i][4], STEPS[i][3], int'(signed'(STEPS[i][2:0])));
    end
    // short pulse dropped, long pulse counted, pause blocks
    input_mode_in = 3'h0;
    filter_ms_in = 8'h02;
    SRC.set_pins(1'b1, 1'b0);
    step(2);
    SRC.set_pins(1'b0, 1'b0);
    step(30);
    ev(1'b1, 1'b0, 1);
    step(20);
    ev(1'b0, 1'b0, 0);
    step(20);
    filter_ms_in = 8'h00;
    pause_pin_in = 1'b1;
    step(20);
    pul(1);
    pause_pin_in = 1'b0;
    step(20);
    // reset pin keeps a 2 ms minimum
    filter_ms_in = 8'h01;
    reset_pin_in = 1'b1;
    step(2);
    reset_pin_in = 1'b0;
    step(20);
    reset_pin_in = 1'b1;
    exp_q.push_back(20'h00000);
    step(20);
    reset_pin_in = 1'b0;
    step(20);
    // manual batches, outputs and resets
    filter_ms_in = 8'h00;
    mon_on = 1'b0;
    count_setpoint_in = 20'h00003;
    pul(3);
    wait_bc(20'h00001);
    `CHK(count_out, 20'h00000)
    `CHK(out2_out, 1'b0)
    pul(3);
    wait_bc(20'h00002);
    `CHK(out1_out, 1'b1)
    batch_shown_in = 1'b1;
    key();
    `CHK({batch_count_out, out1_out}, 21'h000000)
    batch_shown_in = 1'b0;
    pul(1);
    key();
    `CHK({count_out, out2_out}, 21'h000001)
    decrement_mode_in = 1'b1;
    key();
    `CHK(count_out, 20'h00003)
    decrement_mode_in = 1'b0;
    key();
    // automatic batches with timed second output
    batch_auto_in = 1'b1;
    out2_pulse_ms_in = 14'h0008;
    pul(3);
    wait_bc(20'h00001);
    `CHK(out2_out, 1'b0)
    step(20);
    `CHK(out2_out, 1'b1)
    pul(3);
    wait_bc(20'h00000);
    `CHK(out1_out, 1'b1)
    // restore from retained memory
    key();
    mon_on = 1'b1;
    retain_en_in = 1'b1;
    seed = lfsr(seed);
    nv_data_in = {5'h01, seed[14:0]};
    exp_q.push_back(nv_data_in);
    nv_restore_in = 1'b1;
    step(1);
    nv_restore_in = 1'b0;
    step(10);
    `CHK(nv_data_out, nv_data_in)
    // frozen clock enable ignores pin pulses
    clk_en_in = 1'b0;
    pul(1);
    clk_en_in = 1'b1;
    step(10);
    // coefficient 2.0000 doubles the shown count
    coef_in = 20'h04E20;
    step(3);
    `CHK(scaled_count_out, nv_data_in + nv_data_in)
    // random settings for the serial, panel and display logic
    repeat (40) begin
      seed = lfsr(seed);
      {baud_sel_in, dp_sel_in, lockout_in, rtu_sel_in} = seed[9:0];
      {parity_odd_in, stop_two_in, retain_en_in} = seed[12:10];
      {power_fail_in, rx_addr_valid_in} = seed[14:13];
      slave_addr_in = seed[23:16];
      rx_addr_in = seed[24] ? seed[23:16] : seed[31:24];
      coef_in = seed[25] ? 20'h02710 : {4'h0, seed[31:16]};
      step(1);
      power_fail_in = 1'b0;
      rx_addr_valid_in = 1'b0;
      step(4);
    end
    summarize();
  end
endmodule
